// [hdl/fpsc_defs.vh]
// Constants for the front panel and shutdown controller.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
// Function
// - Recording light on whenever unit is operational and ready to record.
// - Retrieval light on in retrieve mode or during satellite time sync.
// - Communication light on retrieval traffic, sync stage two, USB key.
// - Wraparound light red once storage filled and overwriting began.
// - Error light on error, drive light when engaged, satellite blinks.
// - With recording light on, retrieve press toggles retrieve mode.
// - With recording light off ports bypass; retrieve press puts 1,2 inline.
// - Reboot press starts immediate unflushed reboot, may take seconds.
// - Power button configurable: shutdown (default) or reboot.
// - Port light orange at high speed, green on link, off in bypass.
// - Shutdown press: bypass, flush, stop recording; recording light blinks.
// - Flush done: stop blinking, light all indicators, power light off.
// - Shutdown not abortable; buttons ignored until rear power cycled.
// - Reboot-mode power press stops recording, reboots; lights go dark. Code darkens only the recording, retrieval and port lights.
// - Every captured packet stored whole, frame check sequence included.
// - Under heavy 10G load, 10G traffic wins over gigabit ports.
// - Per-port management-accept flag gates management packets.
// - Management-accept flags reset to enabled on every port.
// - Management traffic ignored while retrieve mode is disabled.
// - Inline ports pair one-two, three-four, five-six.
`ifndef FPSC_DEFS_VH
`define FPSC_DEFS_VH
`define FPSC_CLK_MHZ       125
`define FPSC_DEBOUNCE_US   10
`define FPSC_DEBOUNCE_CYC  (`FPSC_DEBOUNCE_US * `FPSC_CLK_MHZ)
`define FPSC_BLINK_MS      250
`define FPSC_BLINK_CYC     (`FPSC_BLINK_MS * 1000 * `FPSC_CLK_MHZ)
`define FPSC_NPORT         6
`define FPSC_OFF_CTRL      12'h000
`define FPSC_OFF_STATUS    12'h004
`define FPSC_OFF_MGMT      12'h008
`define FPSC_OFF_PORTMODE  12'h00c
`define FPSC_CTRL_PWRRB    0
`define FPSC_CTRL_RETBOOT  1
`define FPSC_CTRL_FLUSHOK  2
`define FPSC_CTRL_RST      32'h0000_0000
`define FPSC_MGMT_RST      6'h3f
`endif

// [hdl/fpsc_top.v]
// Front panel lights, buttons, port modes and shutdown sequence.
// Assumes buttons and rear switch sense are asynchronous pins; status
// levels from the capture datapath are on the same clock.
// Every output is registered, so the datapath sees each request one
// cycle after the sequencer decides it; nothing here needs a faster
// response than that.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defs.vh"
module fpsc_top #(
   parameter DEBOUNCE_CYC = `FPSC_DEBOUNCE_CYC,
   parameter BLINK_CYC    = `FPSC_BLINK_CYC
) (
   // Clock and reset
   input  wire        clock,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Front panel buttons and rear power sense, asynchronous
   input  wire        btn_retrieve,
   input  wire        btn_reboot,
   input  wire        btn_power,
   input  wire        rear_power_on,
   // Datapath status
   input  wire        sys_ready,
   input  wire        sync_active,
   input  wire        sync_stage2,
   input  wire        retr_comm,
   input  wire        usb_comm,
   input  wire        wrapped,
   input  wire        error_flag,
   input  wire        drive_busy,
   input  wire [5:0]  port_link,
   input  wire [5:0]  port_fast,
   input  wire [5:0]  mgmt_pkt_seen,
   input  wire        load_10g_high,
   input  wire        flush_done,
   // Indicators
   output reg         recording_indicator,
   output reg         retrieval_indicator,
   output reg         comm_indicator,
   output reg         wrap_indicator,
   output reg         error_indicator,
   output reg         drive_activity_indicator,
   output reg         sat_indicator,
   output reg         power_btn_light,
   output reg  [5:0]  port_green,
   output reg  [5:0]  port_orange,
   // Datapath control
   output reg  [5:0]  port_inline,
   output reg  [5:0]  mgmt_accept,
   output reg         rec_enable,
   output reg         flush_req,
   output reg         reboot_req,
   output reg         keep_fcs,
   output reg         gbe_throttle
);
   localparam ST_RUN   = 2'd0;
   localparam ST_FLUSH = 2'd1;
   localparam ST_DONE  = 2'd2;
   localparam ST_RBT   = 2'd3;
   // Run: all buttons live, lights follow the datapath status.
   // Flush: bypass held and buffers draining; recording light blinks.
   // Done: everything lit but the power light; buttons stay dead until the rear switches
   // have gone off and on again, since the unit is about to lose power.
   // Reboot: recording, retrieval and port lights dark until the
   // datapath drops ready.

   reg [1:0]  state_r;
   reg        retmode_r;
   reg        pwr_reboot_r;
   reg        ret_boot_r;
   reg [5:0]  mgmt_en_r;
   reg        blink_r;
   reg [31:0] blink_cnt_r;
   reg        was_off_r;
   reg [1:0]  rear_sync_r;

   // Two-stage synchronisers and debounce per button. A level must hold
   // for the whole debounce count before it is believed, so a bouncing
   // contact costs latency, never a second press. Only the rising edge
   // of the filtered level makes an event; release is filtered too.
   wire [2:0] btn_raw = {btn_power, btn_reboot, btn_retrieve};
   wire [2:0] press;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gdb
         reg [1:0]  sync_r;
         reg        stable_r;
         reg        pulse_r;
         reg [15:0] cnt_r;
         always @(posedge clock or posedge reset) begin
            if (reset) begin
               sync_r   <= 2'b00;
               stable_r <= 1'b0;
               pulse_r  <= 1'b0;
               cnt_r    <= 16'h0000;
            end else begin
               sync_r  <= {sync_r[0], btn_raw[g]};
               pulse_r <= 1'b0;
               // Counter restarts whenever the raw level agrees again
               if (sync_r[1] == stable_r) begin
                  cnt_r <= 16'h0000;
               end else if (cnt_r >= DEBOUNCE_CYC[15:0] - 16'h0001) begin
                  cnt_r    <= 16'h0000;
                  stable_r <= sync_r[1];
                  pulse_r  <= sync_r[1];
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
         end
         assign press[g] = pulse_r;
      end
   endgenerate

   // Buttons are dead after a shutdown starts until rear power is cycled
   wire locked   = (state_r == ST_FLUSH) || (state_r == ST_DONE);
   wire p_ret    = press[0] && !locked;
   wire p_rbt    = press[1] && !locked;
   wire p_pwr    = press[2] && !locked;
   // Recording only counts in run; the flush blinks the light instead
   wire rec_on   = sys_ready && (state_r == ST_RUN);
   wire rear_on  = rear_sync_r[1];

   // Register map, one aligned word each:
   //   control   bit 0 power button reboots, bit 1 retrieve mode at boot
   //   status    retrieve mode, wrapped, state, recording, blink; read only
   //   mgmt      per-port management-accept flags, all set at reset
   //   port mode ports now inline; read only
   // Unmapped words answer with an error, read zero and drop writes.
   function [2:0] reg_index;
      input [11:0] addr;
      begin
         case (addr)
            `FPSC_OFF_CTRL:     reg_index = 3'h0;
            `FPSC_OFF_STATUS:   reg_index = 3'h1;
            `FPSC_OFF_MGMT:     reg_index = 3'h2;
            `FPSC_OFF_PORTMODE: reg_index = 3'h3;
            default:            reg_index = 3'h4;
         endcase
      end
   endfunction

   // APB decode
   wire        apb_acc  = psel && penable && pready;
   wire        apb_wr   = apb_acc && pwrite;
   wire [2:0]  reg_sel  = reg_index(paddr);
   wire        hit_ctrl = (reg_sel == 3'h0);
   wire        hit_stat = (reg_sel == 3'h1);
   wire        hit_mgmt = (reg_sel == 3'h2);
   wire        hit_pm   = (reg_sel == 3'h3);
   wire        mapped   = !reg_sel[2];
   reg  [31:0] rd_nxt;

   // Read mux; unmapped words read zero
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (hit_ctrl)
         rd_nxt = {30'h0, ret_boot_r, pwr_reboot_r};
      else if (hit_stat)
         rd_nxt = {26'h0, retmode_r, wrapped, state_r, rec_on, blink_r};
      else if (hit_mgmt)
         rd_nxt = {26'h0, mgmt_en_r};
      else if (hit_pm)
         rd_nxt = {26'h0, port_inline};
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         // No wait state: answer in the cycle after setup. Read data is
         // captured then and holds through the access phase.
         pready  <= psel && !pready;
         prdata  <= rd_nxt;
         pslverr <= psel && !pready && !mapped;
      end
   end

   // Control and management flags; writes land on the access edge only
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pwr_reboot_r <= 1'b0;
         ret_boot_r   <= 1'b0;
         mgmt_en_r    <= `FPSC_MGMT_RST;
      end else if (apb_wr && hit_ctrl) begin
         pwr_reboot_r <= pwdata[`FPSC_CTRL_PWRRB];
         ret_boot_r   <= pwdata[`FPSC_CTRL_RETBOOT];
      end else if (apb_wr && hit_mgmt) begin
         mgmt_en_r <= pwdata[5:0];
      end
   end

   // Blink timer shared by every blinking light, so they stay in step;
   // its half period sets the visible rate.
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         blink_cnt_r <= 32'h0000_0000;
         blink_r     <= 1'b0;
      end else if (blink_cnt_r >= BLINK_CYC - 1) begin
         blink_cnt_r <= 32'h0000_0000;
         blink_r     <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
   end

   // Shutdown and reboot sequencing
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r     <= ST_RUN;
         rear_sync_r <= 2'b00;
         was_off_r   <= 1'b0;
         retmode_r   <= 1'b0;
      end else begin
         // Rear sense goes through its own two flip-flops
         rear_sync_r <= {rear_sync_r[0], rear_power_on};
         case (state_r)
            ST_RUN: begin
               // A reboot press wins over a power press in the same cycle
               if (p_rbt)
                  state_r <= ST_RBT;
               else if (p_pwr && pwr_reboot_r)
                  state_r <= ST_RBT;
               else if (p_pwr)
                  state_r <= ST_FLUSH;
               if (p_ret && rec_on)
                  retmode_r <= !retmode_r;
            end
            ST_FLUSH: begin
               // Flush done is the only way out: no button aborts it
               was_off_r <= 1'b0;
               if (flush_done)
                  state_r <= ST_DONE;
            end
            ST_DONE: begin
               // Only a full rear off-then-on cycle releases the lock
               if (!rear_on)
                  was_off_r <= 1'b1;
               else if (was_off_r) begin
                  state_r   <= ST_RUN;
                  was_off_r <= 1'b0;
                  retmode_r <= ret_boot_r;
               end
            end
            ST_RBT: begin
               // Reboot done once the unit drops ready
               if (!sys_ready)
                  state_r <= ST_RUN;
               // Retrieve mode restarts from its boot setting
               retmode_r <= ret_boot_r;
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // Datapath control follows the sequencer by one cycle
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mgmt_accept  <= 6'h00;
         rec_enable   <= 1'b0;
         flush_req    <= 1'b0;
         reboot_req   <= 1'b0;
         keep_fcs     <= 1'b1;
         gbe_throttle <= 1'b0;
      end else begin
         // The frame check sequence is never stripped, in any port mode
         keep_fcs     <= 1'b1;
         gbe_throttle <= load_10g_high;
         flush_req    <= (state_r == ST_FLUSH);
         reboot_req   <= (state_r == ST_RBT);
         rec_enable   <= rec_on;
         // Management passes only on flagged ports in retrieve mode
         mgmt_accept  <= mgmt_en_r & {6{retmode_r}}
                         & mgmt_pkt_seen;
      end
   end

   // Ports pair in order; inline only when the unit records. Ports
   // one and two stay inline after a retrieve press until recording
   // starts, so the first route passes traffic before boot is done.
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         port_inline <= 6'h00;
      end else if (state_r != ST_RUN) begin
         port_inline <= 6'h00;
      end else if (rec_on) begin
         port_inline <= 6'h3f;
      end else if (p_ret) begin
         port_inline <= 6'h03;
      end else if (port_inline != 6'h03) begin
         port_inline <= 6'h00;
      end
   end

   // Per-port lights: dark in bypass or without link
   wire [5:0] green_nxt;
   wire [5:0] orange_nxt;
   generate
      for (g = 0; g < `FPSC_NPORT; g = g + 1) begin : gport
         assign green_nxt[g]  = port_link[g] & port_inline[g];
         assign orange_nxt[g] = port_link[g] & port_fast[g] & port_inline[g];
      end
   endgenerate

   // Indicators
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         recording_indicator      <= 1'b0;
         retrieval_indicator      <= 1'b0;
         comm_indicator           <= 1'b0;
         wrap_indicator           <= 1'b0;
         error_indicator          <= 1'b0;
         drive_activity_indicator <= 1'b0;
         sat_indicator            <= 1'b0;
         power_btn_light          <= 1'b0;
         port_green               <= 6'h00;
         port_orange              <= 6'h00;
      end else begin
         case (state_r)
            ST_DONE: begin
               // All lights on but the power light tells the operator it is safe to switch off
               recording_indicator      <= 1'b1;
               retrieval_indicator      <= 1'b1;
               comm_indicator           <= 1'b1;
               wrap_indicator           <= 1'b1;
               error_indicator          <= 1'b1;
               drive_activity_indicator <= 1'b1;
               sat_indicator            <= 1'b1;
               power_btn_light          <= 1'b0;
               port_green               <= 6'h3f;
               port_orange              <= 6'h3f;
            end
            ST_RBT: begin
               recording_indicator <= 1'b0;
               retrieval_indicator <= 1'b0;
               port_green          <= 6'h00;
               port_orange         <= 6'h00;
               // Power light stays on: the unit is not shutting down
               power_btn_light     <= 1'b1;
            end
            default: begin
               // Recording light blinks through the whole flush
               if (state_r == ST_FLUSH)
                  recording_indicator <= blink_r;
               else
                  recording_indicator <= rec_on;
               retrieval_indicator <= retmode_r || sync_active;
               comm_indicator <= retr_comm || sync_stage2
                                 || usb_comm;
               wrap_indicator <= wrapped;
               error_indicator <= error_flag;
               drive_activity_indicator <= drive_busy;
               sat_indicator <= sync_active && blink_r;
               power_btn_light <= 1'b1;
               port_green  <= green_nxt;
               port_orange <= orange_nxt;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [testbench/fpsc_checker.sv]
// Port checker for the front panel controller.
// Assumes one clock domain; bound to every fpsc_top instance.
`timescale 1ns/1ps
`default_nettype none
module fpsc_checker (
   // Clock, reset and bus
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Status and lights
   input wire logic        flush_done,
   input wire logic [5:0]  mgmt_pkt_seen,
   input wire logic        recording_indicator,
   input wire logic        retrieval_indicator,
   input wire logic        comm_indicator,
   input wire logic        error_indicator,
   input wire logic        sat_indicator,
   input wire logic        power_btn_light,
   input wire logic [5:0]  port_green,
   input wire logic [5:0]  port_inline,
   input wire logic [5:0]  mgmt_accept,
   input wire logic        flush_req,
   input wire logic        reboot_req,
   input wire logic        keep_fcs
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_fcs; keep_fcs; endproperty
   a_fcs: assert property (p_fcs) else $error("fcs keep low");
   property p_mgmt;
      (mgmt_accept & ~$past(mgmt_pkt_seen)) == 6'h00;
   endproperty
   a_mgmt: assert property (p_mgmt) else $error("mgmt taken");
   property p_rbt;
      reboot_req |-> ##[0:2] !recording_indicator && !retrieval_indicator
         && port_green == 6'h00;
   endproperty
   a_rbt: assert property (p_rbt) else $error("reboot lights");
   property p_byp; flush_req |-> ##[0:2] port_inline == 6'h00; endproperty
   a_byp: assert property (p_byp) else $error("no bypass");
   property p_done;
      flush_req && flush_done |-> ##[1:3] !power_btn_light && comm_indicator
         && error_indicator && sat_indicator && recording_indicator;
   endproperty
   a_done: assert property (p_done) else $error("flush end");
   property p_keep; flush_req |-> !reboot_req; endproperty
   a_keep: assert property (p_keep) else $error("shutdown aborted");
   property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready timing");
   property p_err;
      pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004
         || paddr == 12'h008 || paddr == 12'h00c);
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   c_done: cover property (flush_req && flush_done);
   c_rbt: cover property (reboot_req);
   c_err: cover property (pready && pslverr);
endmodule
bind fpsc_top fpsc_checker u_chk (.clock, .reset, .psel, .penable, .paddr,
   .pready, .pslverr, .flush_done, .mgmt_pkt_seen, .recording_indicator,
   .retrieval_indicator, .comm_indicator, .error_indicator, .sat_indicator,
   .power_btn_light, .port_green, .port_inline, .mgmt_accept, .flush_req,
   .reboot_req, .keep_fcs);
`default_nettype wire

// [testbench/fpsc_operator.sv]
// Operator at the panel: presses buttons and cycles the rear switches.
// Assumes push and rear_cycle are one-cycle requests from the bench.
`timescale 1ns/1ps
`default_nettype none
module fpsc_operator #(
   parameter HOLD = 10
) (
   input wire logic       clock,
   input wire logic [2:0] push,
   input wire logic       rear_cycle,
   output wire logic      btn_retrieve,
   output wire logic      btn_reboot,
   output wire logic      btn_power,
   output wire logic      rear_power_on
);
   integer     cnt = 0;
   integer     rcnt = 0;
   logic [2:0] which = 3'h0;
   always @(posedge clock) begin
      if (push != 3'h0) begin
         which <= push;
         cnt <= HOLD + 3;
      end else if (cnt > 0) cnt <= cnt - 1;
      if (rear_cycle) rcnt <= 6;
      else if (rcnt > 0) rcnt <= rcnt - 1;
   end
   // Contact bounce: a one-cycle drop early in every press
   assign {btn_power, btn_reboot, btn_retrieve} =
      (cnt > 0 && cnt != HOLD + 1) ? which : 3'h0;
   assign rear_power_on = (rcnt == 0);
endmodule
`default_nettype wire

// [testbench/fpsc_top_test.sv]
// Self-checking bench for fpsc_top with the operator model.
// Assumes shortened debounce and blink counts.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defs.vh"
module fpsc_top_test;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pslverr, e, bret, brbt, bpwr, rear, rc = 0;
   logic sys_ready = 0, sync_active = 0, sync_stage2 = 0, retr_comm = 0;
   logic usb_comm = 0, wrapped = 0, error_flag = 0, drive_busy = 0;
   logic load_10g_high = 0, flush_done = 0;
   logic [5:0] port_link = 0, port_fast = 0, mgmt_pkt_seen = 0;
   logic [2:0] push = 0;
   logic rec_i, ret_i, com_i, wrp_i, err_i, drv_i, sat_i, pwl, rec_en;
   logic flush_req, reboot_req, keep_fcs, gbe_throttle;
   logic [5:0] grn, org, inl, macc;
   integer num_errors = 0, n_compared = 0;
   fpsc_operator op (.clock(clock), .push(push), .rear_cycle(rc),
      .btn_retrieve(bret), .btn_reboot(brbt), .btn_power(bpwr),
      .rear_power_on(rear));
   fpsc_top #(.DEBOUNCE_CYC(4), .BLINK_CYC(8)) dut (.clock(clock),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .btn_retrieve(bret), .btn_reboot(brbt),
      .btn_power(bpwr), .rear_power_on(rear), .sys_ready(sys_ready),
      .sync_active(sync_active), .sync_stage2(sync_stage2),
      .retr_comm(retr_comm), .usb_comm(usb_comm), .wrapped(wrapped),
      .error_flag(error_flag), .drive_busy(drive_busy),
      .port_link(port_link), .port_fast(port_fast),
      .mgmt_pkt_seen(mgmt_pkt_seen), .load_10g_high(load_10g_high),
      .flush_done(flush_done), .recording_indicator(rec_i),
      .retrieval_indicator(ret_i), .comm_indicator(com_i),
      .wrap_indicator(wrp_i), .error_indicator(err_i),
      .drive_activity_indicator(drv_i), .sat_indicator(sat_i),
      .power_btn_light(pwl), .port_green(grn), .port_orange(org),
      .port_inline(inl), .mgmt_accept(macc), .rec_enable(rec_en),
      .flush_req(flush_req), .reboot_req(reboot_req),
      .keep_fcs(keep_fcs), .gbe_throttle(gbe_throttle));
   initial forever #4 clock = ~clock;
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, s, x);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clock);
      penable <= 1;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      chk(n < 20, 1);
      {psel, penable} <= 2'b00;
   endtask
   task press(input logic [2:0] b);
      @(posedge clock) push <= b;
      @(posedge clock) push <= 3'h0;
      repeat (25) @(posedge clock);
   endtask
   task t_regs;
      apb(0, `FPSC_OFF_MGMT, 0); chk(q[5:0], `FPSC_MGMT_RST);
      apb(0, `FPSC_OFF_CTRL, 0); chk(q, `FPSC_CTRL_RST);
      apb(1, 12'h0f0, 32'h1); chk(e, 1);
      apb(0, 12'h0f0, 0); chk(q, 0);
      chk(keep_fcs, 1);
      $display("t_regs done");
   endtask
   task t_lights;
      {sync_stage2, wrapped, error_flag, drive_busy, load_10g_high} <= 5'h1f;
      {sync_active, port_link, port_fast} <= {1'b1, 6'h3f, 6'h0f};
      repeat (20) @(posedge clock);
      chk({com_i, wrp_i, err_i, drv_i}, 4'hf);
      chk(ret_i, 1);
      chk(gbe_throttle, 1);
      {sync_stage2, wrapped, error_flag, drive_busy, load_10g_high} <= 5'h0;
      sync_active <= 0;
      press(3'b001);
      chk(inl, 6'h03);
      chk(rec_i, 0);
      sys_ready <= 1;
      repeat (6) @(posedge clock);
      chk({rec_i, inl}, {1'b1, 6'h3f});
      chk({grn, org}, {6'h3f, 6'h0f});
      $display("t_lights done");
   endtask
   task t_retrieve;
      mgmt_pkt_seen <= 6'h3f;
      apb(1, `FPSC_OFF_MGMT, 32'h05);
      press(3'b001);
      apb(0, `FPSC_OFF_STATUS, 0); chk(q[5], 1);
      chk(ret_i, 1);
      chk(macc, 6'h05);
      press(3'b001);
      apb(0, `FPSC_OFF_STATUS, 0); chk(q[5], 0);
      chk(macc, 6'h00);
      $display("t_retrieve done");
   endtask
   task t_reboot(input logic cfg);
      apb(1, `FPSC_OFF_CTRL, {30'h0, cfg, cfg});
      press(cfg ? 3'b100 : 3'b010);
      chk({reboot_req, flush_req, rec_i}, 3'b100);
      sys_ready <= 0;
      repeat (6) @(posedge clock);
      sys_ready <= 1;
      repeat (6) @(posedge clock);
      chk(ret_i, cfg);
      $display("t_reboot done");
   endtask
   task t_shutdown;
      logic s0, s1;
      s0 = 0;
      s1 = 0;
      apb(1, `FPSC_OFF_CTRL, 0);
      press(3'b100);
      chk({flush_req, inl}, {1'b1, 6'h00});
      repeat (40) begin
         @(posedge clock);
         if (rec_i === 1'b0) s0 = 1;
         if (rec_i === 1'b1) s1 = 1;
      end
      chk({s0, s1}, 2'b11);
      press(3'b010);
      chk(reboot_req, 0);
      flush_done <= 1;
      repeat (6) @(posedge clock);
      chk({pwl, rec_i, ret_i, err_i, sat_i}, 5'b01111);
      flush_done <= 0;
      press(3'b001);
      chk({pwl, reboot_req}, 2'b00);
      @(posedge clock) rc <= 1;
      @(posedge clock) rc <= 0;
      repeat (15) @(posedge clock);
      chk({pwl, flush_req, rec_i}, 3'b101);
      $display("t_shutdown done");
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (12) @(posedge clock);
      reset <= 0;
      repeat (2) @(posedge clock);
      t_regs;
      t_lights;
      t_retrieve;
      t_reboot(0);
      t_reboot(1);
      t_shutdown;
      give_verdict;
   end
endmodule
`default_nettype wire
